// ### dv/can_node_model.sv
// Far-side CAN node model: delivers frames and completes transmissions
`timescale 1ns/1ps
module can_node_model
(
   input wire core_clk_in,
   input wire reset_n_in,
   input wire [14:0] tx_request_in,
   input wire [7:0] delay_in,
   output reg rx_load_out,
   output reg [31:0] rx_id_out,
   output reg [3:0] rx_dlc_out,
   output reg [63:0] rx_data_out,
   output reg rx_remote_out,
   output reg rx_valid_point_out,
   output reg [14:0] tx_done_out
);
reg [7:0] wait_ff;
initial
begin
   rx_load_out = 1'h0;
   rx_id_out = 32'h0000_0000;
   rx_dlc_out = 4'h0;
   rx_data_out = 64'h0;
   rx_remote_out = 1'h0;
   rx_valid_point_out = 1'h0;
end
task send(input [31:0] id, input [3:0] dlc, input [63:0] data, input rem);
   begin
      @(posedge core_clk_in);
      rx_load_out <= 1'h1;
      rx_id_out <= id;
      rx_dlc_out <= dlc;
      rx_data_out <= data;
      rx_remote_out <= rem;
      @(posedge core_clk_in);
      // Fields mean nothing after the load, so they are scrambled
      rx_load_out <= 1'h0;
      rx_id_out <= ~id;
      rx_dlc_out <= ~dlc;
      rx_data_out <= ~data;
      rx_remote_out <= ~rem;
      repeat (3) @(posedge core_clk_in);
      rx_valid_point_out <= 1'h1;
      @(posedge core_clk_in);
      rx_valid_point_out <= 1'h0;
      repeat (12) @(posedge core_clk_in);
   end
endtask
// Lowest pending buffer finishes first, after a chosen bus delay
always @(posedge core_clk_in or negedge reset_n_in)
begin
   if (!reset_n_in)
   begin
      tx_done_out <= 15'h0000;
      wait_ff <= 8'h00;
   end
   else
   begin
      tx_done_out <= 15'h0000;
      wait_ff <= 8'h00;
      if (tx_request_in != 15'h0000 && tx_done_out == 15'h0000)
      begin
         if (wait_ff == delay_in)
            tx_done_out <= tx_request_in & (~tx_request_in + 15'h0001);
         else
            wait_ff <= wait_ff + 8'h01;
      end
   end
end
endmodule

// ### dv/can_rx_assertions.sv
// Port checker for the CAN receive filter and buffer store
`timescale 1ns/1ps
`include "can_rx_consts.vh"
module can_rx_assertions
(
   input wire core_clk_in,
   input wire reset_n_in,
   input wire s_axi_awready_out,
   input wire s_axi_wready_out,
   input wire [1:0] s_axi_bresp_out,
   input wire s_axi_bvalid_out,
   input wire s_axi_bready_in,
   input wire s_axi_arready_out,
   input wire [31:0] s_axi_rdata_out,
   input wire [1:0] s_axi_rresp_out,
   input wire s_axi_rvalid_out,
   input wire s_axi_rready_in,
   input wire rx_valid_point_in,
   input wire copy_busy_out,
   input wire tq_tick_out,
   input wire bit_tick_out
);
default clocking @(posedge core_clk_in); endclocking
default disable iff (!reset_n_in);
chk_bit_on_quantum: assert property (bit_tick_out |-> tq_tick_out)
   else $error("bit tick without quantum tick");
chk_copy_length: assert property ($rose(copy_busy_out) |-> copy_busy_out[*8] ##1 !copy_busy_out)
   else $error("copy busy length wrong");
chk_copy_cause: assert property ($rose(copy_busy_out) |-> $past(rx_valid_point_in, 2))
   else $error("copy started without validation");
chk_bresp_hold: assert property (s_axi_bvalid_out && !s_axi_bready_in
   |=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
   else $error("write response dropped");
chk_rdata_hold: assert property (s_axi_rvalid_out && !s_axi_rready_in
   |=> s_axi_rvalid_out && $stable(s_axi_rdata_out) && $stable(s_axi_rresp_out))
   else $error("read data dropped");
chk_ar_blocked: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
   else $error("read address open while data pending");
chk_bresp_after: assert property ($rose(s_axi_bvalid_out)
   |-> !$past(s_axi_awready_out) && !$past(s_axi_wready_out))
   else $error("response without held write");
chk_refused_zero: assert property (s_axi_rvalid_out && s_axi_rresp_out == `RESP_SLVERR
   |-> s_axi_rdata_out == 32'h0000_0000)
   else $error("refused read returned data");
endmodule
bind can_rx_filter_buffer_store can_rx_assertions chk_i
(
   .core_clk_in(core_clk_in), .reset_n_in(reset_n_in),
   .s_axi_awready_out(s_axi_awready_out), .s_axi_wready_out(s_axi_wready_out),
   .s_axi_bresp_out(s_axi_bresp_out), .s_axi_bvalid_out(s_axi_bvalid_out),
   .s_axi_bready_in(s_axi_bready_in), .s_axi_arready_out(s_axi_arready_out),
   .s_axi_rdata_out(s_axi_rdata_out), .s_axi_rresp_out(s_axi_rresp_out),
   .s_axi_rvalid_out(s_axi_rvalid_out), .s_axi_rready_in(s_axi_rready_in),
   .rx_valid_point_in(rx_valid_point_in), .copy_busy_out(copy_busy_out),
   .tq_tick_out(tq_tick_out), .bit_tick_out(bit_tick_out)
);

// ### dv/testbench.sv
// Self-checking bench for the CAN receive filter and buffer store
`timescale 1ns/1ps
`include "can_rx_consts.vh"
module testbench;
reg clk = 1'h0;
reg rst_n = 1'h0;
reg [11:0] awaddr = 12'h000, araddr = 12'h000;
reg [31:0] wdata = 32'h0000_0000, x, z, w, r;
reg awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
reg [7:0] dly = 8'h01, quantum_prescale_value;
reg [3:0] t1, fl;
reg [2:0] t2;
reg [63:0] fd;
wire awready, wready, bvalid, arready, rvalid, rx_load, rx_rem, rx_vp, busy, tq, bt;
wire [1:0] bresp, rresp;
wire [31:0] rdata, rx_id;
wire [3:0] rx_dlc;
wire [63:0] rx_data;
wire [14:0] tx_done, tx_req;
integer mismatches = 0, checked = 0, i, n;
reg [33:0] rq[$];
reg [1:0] bq[$];
always #50 clk = ~clk;
can_rx_filter_buffer_store dut
(
   .core_clk_in(clk), .reset_n_in(rst_n), .s_axi_awaddr_in(awaddr),
   .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
   .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
   .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
   .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
   .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
   .s_axi_rready_in(rready), .rx_load_in(rx_load), .rx_id_in(rx_id), .rx_dlc_in(rx_dlc),
   .rx_data_in(rx_data), .rx_remote_in(rx_rem), .rx_valid_point_in(rx_vp),
   .tx_done_in(tx_done), .tx_request_out(tx_req), .copy_busy_out(busy),
   .tq_tick_out(tq), .bit_tick_out(bt)
);
can_node_model node
(
   .core_clk_in(clk), .reset_n_in(rst_n), .tx_request_in(tx_req), .delay_in(dly),
   .rx_load_out(rx_load), .rx_id_out(rx_id), .rx_dlc_out(rx_dlc),
   .rx_data_out(rx_data), .rx_remote_out(rx_rem), .rx_valid_point_out(rx_vp),
   .tx_done_out(tx_done)
);
function [11:0] ad(input [3:0] b, input [2:0] wd);
   ad = {3'h0, b, wd, 2'h0};
endfunction
task cmp(input [33:0] got, input [33:0] exp);
   begin
      checked = checked + 1;
      if (got !== exp)
      begin
         mismatches = mismatches + 1;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   end
endtask
task waitv(input s);
   reg p;
   begin
      p = 1'h0;
      while (p !== 1'h1)
      begin
         #1 p = s ? rvalid : bvalid;
         @(posedge clk);
      end
   end
endtask
task wr(input [11:0] a, input [31:0] d, input [1:0] e);
   reg ta, tw, pa, pw;
   begin
      bq.push_back(e);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      ta = 1'h0;
      tw = 1'h0;
      while (!(ta && tw))
      begin
         #1 pa = awready & ~ta;
         pw = wready & ~tw;
         @(posedge clk);
         if (pa) awvalid <= 1'h0;
         if (pw) wvalid <= 1'h0;
         ta = ta | pa;
         tw = tw | pw;
      end
      repeat ($urandom % 3) @(posedge clk);
      bready <= 1'h1;
      waitv(1'h0);
      bready <= 1'h0;
   end
endtask
task rd(input [11:0] a, input [31:0] d, input [1:0] e);
   reg p;
   begin
      rq.push_back({e, d});
      araddr <= a;
      arvalid <= 1'h1;
      p = 1'h0;
      while (p !== 1'h1)
      begin
         #1 p = arready;
         @(posedge clk);
      end
      arvalid <= 1'h0;
      repeat ($urandom % 3) @(posedge clk);
      rready <= 1'h1;
      waitv(1'h1);
      rready <= 1'h0;
   end
endtask
always @(negedge clk)
begin
   if ((rvalid & rready) === 1'h1) cmp({rresp, rdata}, rq.pop_front());
   if ((bvalid & bready) === 1'h1) cmp({32'h0, bresp}, {32'h0, bq.pop_front()});
end
task setbuf(input [3:0] b, input [31:0] id, input [3:0] st);
   begin
      wr(ad(b, 1), {16'h0000, id[31:16]}, `RESP_OKAY);
      wr(ad(b, 2), {16'h0000, id[15:0]}, `RESP_OKAY);
      wr(ad(b, 0), {28'h0, st}, `RESP_OKAY);
   end
endtask
task chkbuf(input [3:0] b, input [31:0] id, input [3:0] dl, input [63:0] d, input [3:0] st);
   integer j;
   begin
      rd(ad(b, 0), {20'h0, dl, 4'h0, st}, `RESP_OKAY);
      rd(ad(b, 1), {16'h0000, id[31:16]}, `RESP_OKAY);
      rd(ad(b, 2), {16'h0000, id[15:0]}, `RESP_OKAY);
      for (j = 0; j < 4; j = j + 1)
         rd(ad(b, j[2:0] + 3'h3), {16'h0000, d[16*j +: 16]}, `RESP_OKAY);
   end
endtask
task frame(input [31:0] id);
   begin
      fd = {$urandom, $urandom};
      fl = $urandom;
      node.send(id, fl, fd, 1'h0);
   end
endtask
task gap(input s, input integer e);
   begin
      @(negedge clk);
      while ((s ? bt : tq) !== 1'h1) @(negedge clk);
      @(negedge clk);
      n = 1;
      while ((s ? bt : tq) !== 1'h1 && n < 500)
      begin
         n = n + 1;
         @(negedge clk);
      end
      cmp(n, e);
      @(posedge clk);
   end
endtask
task drain;
   begin
      n = 0;
      while (tx_req !== 15'h0000 && n < 1000)
      begin
         @(negedge clk);
         n = n + 1;
      end
      cmp(tx_req, 15'h0000);
      @(posedge clk);
   end
endtask
task summarize;
   begin
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   end
endtask
initial
begin
   #(100 * 30000);
   mismatches = mismatches + 1;
   $display("BAD %0t watchdog expired", $time);
   summarize;
end
initial
begin
   n = $urandom(47);
   repeat (4) @(posedge clk);
   rst_n <= 1'h1;
   @(posedge clk);
   rd(`OFS_TIMING, `TIMING_RST, `RESP_OKAY);
   rd(12'h300, 32'h0000_0000, `RESP_SLVERR);
   wr(12'h300, 32'hFFFF_FFFF, `RESP_SLVERR);
   quantum_prescale_value = 8'h01 + $urandom % 8;
   t1 = $urandom;
   t2 = $urandom;
   wr(`OFS_TIMING, {17'h0, t2, t1, quantum_prescale_value}, `RESP_OKAY);
   rd(`OFS_TIMING, {17'h0, t2, t1, quantum_prescale_value}, `RESP_OKAY);
   repeat (200) @(posedge clk);
   gap(1'h0, quantum_prescale_value);
   gap(1'h1, quantum_prescale_value * (1 + t1 + t2));
   $display("test timing done");
   x = $urandom;
   for (i = 0; i < 15; i = i + 1)
      setbuf(i[3:0], x, (i == 3 || i == 5 || i == 14) ? `ST_RX_ARMED : `ST_RX_IDLE);
   wr(`OFS_CAMASK, 32'hFFFF_FFFF, `RESP_OKAY);
   frame(x);
   chkbuf(4'h3, x, fl, fd, `ST_RX_FULL);
   rd(ad(4'h5, 0), {28'h0, `ST_RX_ARMED}, `RESP_OKAY);
   rd(ad(4'hE, 0), {28'h0, `ST_RX_ARMED}, `RESP_OKAY);
   rd(ad(4'h0, 0), {28'h0, `ST_RX_IDLE}, `RESP_OKAY);
   $display("test first match done");
   wr(`OFS_SHMASK, 32'h0000_00FF, `RESP_OKAY);
   z = x ^ (32'h1 + $urandom % 255);
   frame(z);
   chkbuf(4'h3, z, fl, fd, `ST_RX_OVERRUN);
   w = x ^ 32'h8000_0000;
   frame(w);
   chkbuf(4'hE, w, fl, fd, `ST_RX_FULL);
   $display("test masks done");
   wr(`OFS_CONFIG, 32'h0000_0001, `RESP_OKAY);
   wr(ad(4'h3, 0), {28'h0, `ST_RX_ARMED}, `RESP_OKAY);
   wr(ad(4'hE, 0), {28'h0, `ST_RX_ARMED}, `RESP_OKAY);
   for (i = 0; i < 4; i = i + 1)
      node.send(x, i[3:0], fd, 1'h0);
   for (i = 0; i < 3; i = i + 1)
      rd(ad(i == 0 ? 4'h3 : i == 1 ? 4'h5 : 4'hE, 0), {20'h0, i[3:0], 8'h04}, `RESP_OKAY);
   rd(`OFS_LOCKED, 32'h0000_4028, `RESP_OKAY);
   wr(ad(4'h3, 0), {28'h0, `ST_RX_ARMED}, `RESP_OKAY);
   rd(`OFS_LOCKED, 32'h0000_4020, `RESP_OKAY);
   $display("test lock done");
   dly <= 8'h28;
   wr(ad(4'h7, 0), {28'h0, `ST_TX_ONCE}, `RESP_OKAY);
   rd(`OFS_TXREQ, 32'h0000_0080, `RESP_OKAY);
   drain;
   rd(ad(4'h7, 0), {28'h0, `ST_TX_IDLE}, `RESP_OKAY);
   r = x ^ 32'h0F00_0000;
   setbuf(4'h8, r, `ST_TX_RTR);
   setbuf(4'h9, r, `ST_TX_RTR);
   node.send(r, 4'h0, fd, 1'h1);
   rd(`OFS_TXREQ, 32'h0000_0300, `RESP_OKAY);
   drain;
   rd(ad(4'h9, 0), {28'h0, `ST_TX_RTR}, `RESP_OKAY);
   $display("test transmit done");
   summarize;
end
endmodule

// ### rtl/can_rx_consts.vh
// Constants for the CAN receive filter and message buffer store
`ifndef CAN_RX_CONSTS_VH
`define CAN_RX_CONSTS_VH
// Register byte offsets
`define OFS_BUF_LAST 12'h1DC
`define OFS_TIMING 12'h200
`define OFS_SHMASK 12'h204
`define OFS_CAMASK 12'h208
`define OFS_CONFIG 12'h20C
`define OFS_LOCKED 12'h210
`define OFS_TXREQ 12'h214
// Buffer geometry
`define NUM_BUF 15
`define LAST_BUF 4'hE
`define WORDS_PER_BUF 8
`define NUM_WORDS 120
// Word roles inside one buffer
`define W_STATUS 3'h0
`define W_ID_HI 3'h1
`define W_ID_LO 3'h2
`define W_DATA0 3'h3
`define W_LAST 3'h6
// Field positions
`define W0_STAT 3:0
`define W0_DLC 11:8
`define TIM_PSC 7:0
`define TIM_T1 11:8
`define TIM_T2 14:12
`define CFG_LOCK 0
// Reset values
`define TIMING_RST 32'h0000_0001
`define MASK_RST 32'h0000_0000
`define CONFIG_RST 32'h0000_0000
// Buffer status codes
`define ST_RX_IDLE 4'h0
`define ST_RX_ARMED 4'h2
`define ST_RX_BUSY 4'h3
`define ST_RX_FULL 4'h4
`define ST_RX_OVR_BUSY 4'h5
`define ST_RX_OVERRUN 4'h6
`define ST_TX_IDLE 4'h8
`define ST_TX_RTR 4'hA
`define ST_TX_ONCE 4'hC
`define ST_TX_ONCE_RTR 4'hE
// Bus responses
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

// ### rtl/can_rx_filter_buffer_store.v
// Receive filter, hidden buffer copy engine, buffer RAM and prescaler
`timescale 1ns/1ps
`include "can_rx_consts.vh"

// How it works
// - Time quantum tick divides the core clock by the prescale value.
// - Bit tick every one plus first plus second segment quanta.
// - Fifteen buffers of eight 16-bit words, receive or transmit by status.
// - Each received frame goes into exactly the first matching buffer.
// - Software writing a send-once status (1100 or 1110) schedules that buffer for sending.
// - Remote frame schedules every matching remote-answer buffer at once.
// - Buffers 0 to 13 filter with the shared 32-bit mask.
// - Buffer 14 filters with its own catch-all 32-bit mask.
// - Mask bit one makes that identifier bit don't-care.
// - All-zero mask accepts only the exact stored identifier.
// - Scan 0 to 13 ascending, buffer 14 only if none took it.
// - Only receive-armed or holding buffers take part, by id, mask, status.
// - With lock enabled a filled buffer locks until software re-arms it.
// - Locked buffers are skipped; if all matches locked, frame is dropped.
// - Frame sits in a hidden buffer until the validation point.
// - The hidden buffer has no software access path.
// - The hidden identifier, length and data are copied; the hidden remote flag is not.
// - Length code is not matched; copy replaces the target length.
// - Remote frames store like data frames when the id matches; the RTR flag is not compared.
// - After the first match the request is done; no further buffer.
// - First segment is four bits, second segment three bits.
// - Status codes idle 0000, armed 0010, full 0100, overwrite busy 0101.
// - Copy into an unread buffer ends in the overrun state.
module can_rx_filter_buffer_store
(
   input wire core_clk_in,
   input wire reset_n_in,
   input wire [11:0] s_axi_awaddr_in,
   input wire s_axi_awvalid_in,
   output wire s_axi_awready_out,
   input wire [31:0] s_axi_wdata_in,
   input wire [3:0] s_axi_wstrb_in,
   input wire s_axi_wvalid_in,
   output wire s_axi_wready_out,
   output wire [1:0] s_axi_bresp_out,
   output wire s_axi_bvalid_out,
   input wire s_axi_bready_in,
   input wire [11:0] s_axi_araddr_in,
   input wire s_axi_arvalid_in,
   output wire s_axi_arready_out,
   output wire [31:0] s_axi_rdata_out,
   output wire [1:0] s_axi_rresp_out,
   output wire s_axi_rvalid_out,
   input wire s_axi_rready_in,
   input wire rx_load_in,
   input wire [31:0] rx_id_in,
   input wire [3:0] rx_dlc_in,
   input wire [63:0] rx_data_in,
   input wire rx_remote_in,
   input wire rx_valid_point_in,
   input wire [14:0] tx_done_in,
   output wire [14:0] tx_request_out,
   output wire copy_busy_out,
   output wire tq_tick_out,
   output wire bit_tick_out
);
   localparam [4:0] S_IDLE = 5'b00001;
   localparam [4:0] S_SCAN = 5'b00010;
   localparam [4:0] S_BUSY = 5'b00100;
   localparam [4:0] S_COPY = 5'b01000;
   localparam [4:0] S_DONE = 5'b10000;

   reg [15:0] mem [0:`NUM_WORDS-1];
   reg [31:0] timing_ff;
   reg [31:0] shmask_ff;
   reg [31:0] camask_ff;
   reg [31:0] config_ff;
   reg [14:0] lock_ff;
   reg [14:0] txreq_ff;
   reg [4:0] state_ff;
   reg [3:0] win_ff;
   reg [2:0] cnt_ff;
   reg [3:0] tgt_ff;
   reg [3:0] nxt_tgt;
   // Hidden receive buffer, deliberately outside the address map
   reg [31:0] hid_id_ff;
   reg [3:0] hid_dlc_ff;
   reg [63:0] hid_data_ff;
   reg hid_remote_ff;
   reg [7:0] tq_cnt_ff;
   reg [4:0] q_cnt_ff;
   reg tq_tick_ff;
   reg bit_tick_ff;
   reg aw_hold_ff;
   reg [11:0] aw_addr_ff;
   reg w_hold_ff;
   reg [31:0] w_data_ff;
   reg [3:0] w_strb_ff;
   reg bvalid_ff;
   reg [1:0] bresp_ff;
   reg rvalid_ff;
   reg [31:0] rdata_ff;
   reg [1:0] rresp_ff;

   // Prescaler: a value of zero is treated as one
   wire [7:0] quantum_prescale_value = timing_ff[`TIM_PSC];
   wire [7:0] psc_last = (quantum_prescale_value == 8'h00) ? 8'h00 : quantum_prescale_value - 8'h01;
   wire [4:0] q_last = {1'b0, timing_ff[`TIM_T1]} + {2'b00, timing_ff[`TIM_T2]};

   always @(posedge core_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         tq_cnt_ff <= 8'h00;
         q_cnt_ff <= 5'h00;
         tq_tick_ff <= 1'b0;
         bit_tick_ff <= 1'b0;
      end
      else
      begin
         tq_tick_ff <= 1'b0;
         bit_tick_ff <= 1'b0;
         if (tq_cnt_ff >= psc_last)
         begin
            tq_cnt_ff <= 8'h00;
            tq_tick_ff <= 1'b1;
            if (q_cnt_ff >= q_last)
            begin
               q_cnt_ff <= 5'h00;
               bit_tick_ff <= 1'b1;
            end
            else
               q_cnt_ff <= q_cnt_ff + 5'h01;
         end
         else
            tq_cnt_ff <= tq_cnt_ff + 8'h01;
      end
   end

   // Acceptance filter for every buffer, evaluated in parallel
   wire [14:0] rx_cand;
   wire [14:0] rtr_trig;
   genvar g;
   generate
      for (g = 0; g < `NUM_BUF; g = g + 1)
      begin : flt
         wire [3:0] st = mem[g*8][`W0_STAT];
         wire [31:0] bid = {mem[g*8+1], mem[g*8+2]};
         wire [31:0] msk = (g == 14) ? camask_ff : shmask_ff;
         // Length code deliberately left out of the compare
         wire hit = (((bid ^ hid_id_ff) & ~msk) == 32'h0000_0000);
         wire rx_st = (st == `ST_RX_ARMED) || (st == `ST_RX_FULL) ||
                      (st == `ST_RX_OVERRUN);
         assign rx_cand[g] = hit && rx_st && !lock_ff[g];
         assign rtr_trig[g] = hit && hid_remote_ff && (st == `ST_TX_RTR);
      end
   endgenerate

   // First match in ascending order, buffer 14 last
   reg [3:0] win;
   reg found;
   integer i;
   always @*
   begin
      win = 4'h0;
      found = 1'b0;
      for (i = 0; i < `NUM_BUF; i = i + 1)
      begin
         if (!found && rx_cand[i])
         begin
            win = i[3:0];
            found = 1'b1;
         end
      end
   end

   // Bus write decode
   wire wr_go = aw_hold_ff && w_hold_ff && !bvalid_ff;
   wire wr_buf = wr_go && (aw_addr_ff <= `OFS_BUF_LAST);
   wire [6:0] wr_idx = aw_addr_ff[8:2];
   wire [3:0] wr_bnum = wr_idx[6:3];
   wire wr_stword = (wr_idx[2:0] == `W_STATUS);
   wire copying = (state_ff == S_BUSY) || (state_ff == S_COPY) || (state_ff == S_DONE);
   wire wr_on_win = wr_buf && copying && (wr_bnum == win_ff);
   // No word of the receiving buffer is written by software during the copy; a status write in S_COPY or S_DONE only steers the final status
   wire cpu_mem_we = wr_buf && !wr_on_win;
   wire [31:0] wmask = {{8{w_strb_ff[3]}}, {8{w_strb_ff[2]}},
                        {8{w_strb_ff[1]}}, {8{w_strb_ff[0]}}};
   wire [15:0] cpu_wd = (mem[wr_idx] & ~wmask[15:0]) | (w_data_ff[15:0] & wmask[15:0]);
   wire [3:0] cpu_st = cpu_wd[`W0_STAT];

   // Copy engine word to write
   wire [6:0] win_base = {win_ff, 3'b000};
   wire [3:0] cur_st = mem[win_base][`W0_STAT];
   reg mem_we;
   reg [6:0] mem_wa;
   reg [15:0] mem_wd;
   always @*
   begin
      mem_we = 1'b0;
      mem_wa = win_base;
      mem_wd = mem[win_base];
      case (state_ff)
         S_BUSY:
         begin
            mem_we = 1'b1;
            if ((cur_st == `ST_RX_FULL) || (cur_st == `ST_RX_OVERRUN))
               mem_wd[`W0_STAT] = `ST_RX_OVR_BUSY;
            else
               mem_wd[`W0_STAT] = `ST_RX_BUSY;
         end
         S_COPY:
         begin
            mem_we = 1'b1;
            mem_wa = win_base + {4'h0, cnt_ff};
            case (cnt_ff)
               `W_ID_HI: mem_wd = hid_id_ff[31:16];
               `W_ID_LO: mem_wd = hid_id_ff[15:0];
               3'h3: mem_wd = hid_data_ff[15:0];
               3'h4: mem_wd = hid_data_ff[31:16];
               3'h5: mem_wd = hid_data_ff[47:32];
               3'h6: mem_wd = hid_data_ff[63:48];
               default: mem_wd = mem[win_base];
            endcase
         end
         S_DONE:
         begin
            mem_we = 1'b1;
            mem_wd[`W0_DLC] = hid_dlc_ff;
            mem_wd[`W0_STAT] = nxt_tgt;
         end
         default:
            mem_we = 1'b0;
      endcase
   end

   // Status written by software in S_COPY or S_DONE reshapes the final status
   always @*
   begin
      nxt_tgt = tgt_ff;
      if (wr_on_win && wr_stword)
      begin
         if (cpu_st == `ST_RX_ARMED)
            nxt_tgt = `ST_RX_FULL;
         else if (cpu_st == `ST_RX_IDLE)
            nxt_tgt = `ST_RX_IDLE;
         else if (cpu_st == `ST_RX_FULL)
            nxt_tgt = `ST_RX_OVERRUN;
      end
   end

   // Buffer RAM: copy engine, transmit bookkeeping and software share it
   integer b;
   integer k;
   always @(posedge core_clk_in)
   begin
      for (b = 0; b < `NUM_BUF; b = b + 1)
      begin
         if ((state_ff == S_SCAN) && rtr_trig[b])
            mem[b*8] <= {mem[b*8][15:4], `ST_TX_ONCE_RTR};
         else if (tx_done_in[b] && txreq_ff[b])
         begin
            if (mem[b*8][`W0_STAT] == `ST_TX_ONCE_RTR)
               mem[b*8] <= {mem[b*8][15:4], `ST_TX_RTR};
            else
               mem[b*8] <= {mem[b*8][15:4], `ST_TX_IDLE};
         end
      end
      if (mem_we)
         mem[mem_wa] <= mem_wd;
      if (cpu_mem_we)
         mem[wr_idx] <= cpu_wd;
   end

   // Frame handling, locks and transmit requests
   always @(posedge core_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         state_ff <= S_IDLE;
         win_ff <= 4'h0;
         cnt_ff <= 3'h0;
         tgt_ff <= `ST_RX_FULL;
         lock_ff <= 15'h0000;
         txreq_ff <= 15'h0000;
         hid_id_ff <= 32'h0000_0000;
         hid_dlc_ff <= 4'h0;
         hid_data_ff <= 64'h0000_0000_0000_0000;
         hid_remote_ff <= 1'b0;
      end
      else
      begin
         // The protocol engine must not reload while a copy is running
         if (rx_load_in && !copying)
         begin
            hid_id_ff <= rx_id_in;
            hid_dlc_ff <= rx_dlc_in;
            hid_data_ff <= rx_data_in;
            hid_remote_ff <= rx_remote_in;
         end
         for (k = 0; k < `NUM_BUF; k = k + 1)
         begin
            if (tx_done_in[k] && txreq_ff[k])
               txreq_ff[k] <= 1'b0;
            if ((state_ff == S_SCAN) && rtr_trig[k])
               txreq_ff[k] <= 1'b1;
         end
         // Software status write last, as in the buffer RAM, so both stay consistent
         if (wr_buf && wr_stword && !wr_on_win)
         begin
            txreq_ff[wr_bnum] <= (cpu_st == `ST_TX_ONCE) || (cpu_st == `ST_TX_ONCE_RTR);
            if (cpu_st == `ST_RX_ARMED)
               lock_ff[wr_bnum] <= 1'b0;
         end
         case (state_ff)
            S_IDLE:
            begin
               if (rx_valid_point_in)
                  state_ff <= S_SCAN;
            end
            S_SCAN:
            begin
               // Winner latched here, before any buffer word is touched
               win_ff <= win;
               if (found)
                  state_ff <= S_BUSY;
               else
                  state_ff <= S_IDLE;
            end
            S_BUSY:
            begin
               if ((cur_st == `ST_RX_FULL) || (cur_st == `ST_RX_OVERRUN))
                  tgt_ff <= `ST_RX_OVERRUN;
               else
                  tgt_ff <= `ST_RX_FULL;
               cnt_ff <= `W_ID_HI;
               state_ff <= S_COPY;
            end
            S_COPY:
            begin
               tgt_ff <= nxt_tgt;
               cnt_ff <= cnt_ff + 3'h1;
               if (cnt_ff == `W_LAST)
                  state_ff <= S_DONE;
            end
            S_DONE:
            begin
               // Lock set after the clear above, so a racing re-arm loses
               if (config_ff[`CFG_LOCK] && (nxt_tgt != `ST_RX_IDLE))
                  lock_ff[win_ff] <= 1'b1;
               state_ff <= S_IDLE;
            end
            default:
               state_ff <= S_IDLE;
         endcase
      end
   end

   // Register file writes
   wire [11:0] wa = aw_addr_ff;
   always @(posedge core_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         timing_ff <= `TIMING_RST;
         shmask_ff <= `MASK_RST;
         camask_ff <= `MASK_RST;
         config_ff <= `CONFIG_RST;
      end
      else if (wr_go)
      begin
         if (wa == `OFS_TIMING)
            timing_ff <= ((timing_ff & ~wmask) | (w_data_ff & wmask)) & 32'h0000_7FFF;
         if (wa == `OFS_SHMASK)
            shmask_ff <= (shmask_ff & ~wmask) | (w_data_ff & wmask);
         if (wa == `OFS_CAMASK)
            camask_ff <= (camask_ff & ~wmask) | (w_data_ff & wmask);
         if (wa == `OFS_CONFIG)
            config_ff <= ((config_ff & ~wmask) | (w_data_ff & wmask)) & 32'h0000_0001;
      end
   end

   wire wr_mapped = (wa <= `OFS_BUF_LAST) || (wa == `OFS_TIMING) ||
                    (wa == `OFS_SHMASK) || (wa == `OFS_CAMASK) ||
                    (wa == `OFS_CONFIG) || (wa == `OFS_LOCKED) || (wa == `OFS_TXREQ);

   // Write channel: address and data are taken in either order
   assign s_axi_awready_out = !aw_hold_ff;
   assign s_axi_wready_out = !w_hold_ff;
   always @(posedge core_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         aw_hold_ff <= 1'b0;
         aw_addr_ff <= 12'h000;
         w_hold_ff <= 1'b0;
         w_data_ff <= 32'h0000_0000;
         w_strb_ff <= 4'h0;
         bvalid_ff <= 1'b0;
         bresp_ff <= `RESP_OKAY;
      end
      else
      begin
         if (s_axi_awvalid_in && !aw_hold_ff)
         begin
            aw_hold_ff <= 1'b1;
            aw_addr_ff <= {s_axi_awaddr_in[11:2], 2'b00};
         end
         if (s_axi_wvalid_in && !w_hold_ff)
         begin
            w_hold_ff <= 1'b1;
            w_data_ff <= s_axi_wdata_in;
            w_strb_ff <= s_axi_wstrb_in;
         end
         if (wr_go)
         begin
            aw_hold_ff <= 1'b0;
            w_hold_ff <= 1'b0;
            bvalid_ff <= 1'b1;
            bresp_ff <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
         end
         else if (bvalid_ff && s_axi_bready_in)
            bvalid_ff <= 1'b0;
      end
   end

   // Read channel
   wire [11:0] ra = {s_axi_araddr_in[11:2], 2'b00};
   reg [31:0] rd_val;
   reg rd_ok;
   always @*
   begin
      rd_val = 32'h0000_0000;
      rd_ok = 1'b1;
      if (ra <= `OFS_BUF_LAST)
         rd_val = {16'h0000, mem[ra[8:2]]};
      else if (ra == `OFS_TIMING)
         rd_val = timing_ff;
      else if (ra == `OFS_SHMASK)
         rd_val = shmask_ff;
      else if (ra == `OFS_CAMASK)
         rd_val = camask_ff;
      else if (ra == `OFS_CONFIG)
         rd_val = config_ff;
      else if (ra == `OFS_LOCKED)
         rd_val = {16'h0000, copying, lock_ff};
      else if (ra == `OFS_TXREQ)
         rd_val = {17'h0_0000, txreq_ff};
      else
         rd_ok = 1'b0;
   end

   assign s_axi_arready_out = !rvalid_ff;
   always @(posedge core_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         rvalid_ff <= 1'b0;
         rdata_ff <= 32'h0000_0000;
         rresp_ff <= `RESP_OKAY;
      end
      else if (s_axi_arvalid_in && !rvalid_ff)
      begin
         rvalid_ff <= 1'b1;
         rdata_ff <= rd_val;
         rresp_ff <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (rvalid_ff && s_axi_rready_in)
         rvalid_ff <= 1'b0;
   end

   assign s_axi_bvalid_out = bvalid_ff;
   assign s_axi_bresp_out = bresp_ff;
   assign s_axi_rvalid_out = rvalid_ff;
   assign s_axi_rdata_out = rdata_ff;
   assign s_axi_rresp_out = rresp_ff;
   assign tx_request_out = txreq_ff;
   assign copy_busy_out = copying;
   assign tq_tick_out = tq_tick_ff;
   assign bit_tick_out = bit_tick_ff;
endmodule
